// ==== hdl/ehf_consts.svh ====
// register map, field positions and reset values of the embedded function
`ifndef EHF_CONSTS_SVH
`define EHF_CONSTS_SVH

// register byte offsets on the avalon slave
`define EHF_FADDR_OFS 8'h00
`define EHF_INT_OFS 8'h04
`define EHF_MASK_OFS 8'h08
`define EHF_EP0_CTL_OFS 8'h0c
`define EHF_EP1_DATA_OFS 8'h10
`define EHF_EP1_BCNT_OFS 8'h14
`define EHF_EP1_CTL_OFS 8'h18
`define EHF_EP1_STAT_OFS 8'h1c
`define EHF_EP1_FLAG_OFS 8'h20
`define EHF_SETUP_LO_OFS 8'h24
`define EHF_SETUP_HI_OFS 8'h28

// interrupt register bits
`define EHF_INT_EP0_RX 0
`define EHF_INT_EP0_TX 1
`define EHF_INT_EP1_TX 2
`define EHF_INT_FUNCTION_RESET_FLAG 3
// function address register
`define EHF_FADDR_FEN 7
// ep1 transmit control / status / flag bits
`define EHF_CTL_CLR 7
`define EHF_CTL_SOW 6
`define EHF_CTL_STL 3
`define EHF_CTL_FEN 1
`define EHF_CTL_EN 0
`define EHF_STAT_SEQ 7
`define EHF_FLAG_TX_FIFO_OVERRUN_FLAG 0

// standard request that the function decodes itself
`define EHF_REQ_SET_ADDR 8'h05
`define EHF_RTYPE_STD_DEV 8'h00
// reset value of every function register except the ep1 flag register, which reads 8'h08 (fifo empty)
`define EHF_RESET_VAL 8'h00

`endif

// ==== hdl/ehf_pkg.sv ====
// types shared by the embedded function control logic
package ehf_pkg;
  typedef enum logic [1:0] {EHF_PID_SETUP, EHF_PID_IN, EHF_PID_OUT} ehf_pid_t;
  typedef enum logic [1:0] {EHF_RSP_ACK, EHF_RSP_DATA, EHF_RSP_NACK,
                            EHF_RSP_STALL} ehf_rsp_t;
  typedef enum logic [1:0] {EHF_TX_IDLE, EHF_TX_SEND, EHF_TX_WAIT} ehf_tx_t;
  typedef enum logic [2:0] {EHF_CS_IDLE, EHF_CS_DATA_IN, EHF_CS_DATA_OUT,
                            EHF_CS_STATUS_IN, EHF_CS_STATUS_OUT} ehf_cs_t;
endpackage

// ==== hdl/ehf_func_ctrl.sv ====
// embedded usb function control: registers, ep0 routing, ep1 interrupt data
// Contract
// [RL1] after reset come up as plain hub; all function registers at reset value
// [RL2] function address zero at power-up; function starts disconnected
// [RL3] attach to hub port 5 only when ep0 receive and transmit enables set
// [RL4] hub answers its own requests; function keeps a distinct address
// [RL5] irq stays high while any unmasked interrupt bit is pending
// [RL6] masked interrupt bits still set but do not drive irq
// [RL7] host port reset sets function reset flag, interrupt bit 3
// [RL8] function reset clears all but ep0 enables, reset flag and masks
// [RL9] mcu restores configuration first, then clears function reset flag
// [RL10] host powering the function port drives port five power on
// [RL11] host enabling the port sets function enabled flag, address bit 7
// [RL12] set-address decoded here and loaded; other requests go to mcu
// [RL13] control stages routed onto ep0 receive or ep0 transmit by direction
// [RL14] no-data control write: setup on receive, in status on transmit
// [RL15] interrupt data leaves through ep1 transmit, fifo of eight bytes
// [RL16] overfilling ep1 fifo sets overrun flag and ep1 transmit interrupt
// [RL17] fifo clear bit clears itself once the fifo reset is done
// [RL18] clearing overrun flag after fifo clear drops ep1 transmit interrupt
// [RL19] byte count write sets send enable; packet goes at next ep1 in
// [RL20] acked ep1 packet sets ack and interrupt, clears send enable
// [RL21] mcu clearing ack status drops ep1 transmit interrupt
// [RL22] ep1 in without send enable answers nack or stall, status updated
// [RL23] ep1 toggle picks data0/data1, flips on success, written only if override
// [RL24] irq is the or of pending bits anded with their masks
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`include "ehf_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ehf_func_ctrl #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic usb_port_power,
  input wire logic usb_port_enable,
  input wire logic usb_port_reset,
  input wire logic usb_tok_valid,
  input wire logic [1:0] usb_tok_pid,
  input wire logic [6:0] usb_tok_addr,
  input wire logic [3:0] usb_tok_ep,
  input wire logic [63:0] usb_setup_data,
  input wire logic usb_hs_ack,
  input wire logic usb_hs_fail,
  output logic usb_resp_valid,
  output logic [1:0] usb_resp_code,
  output logic usb_resp_data1,
  output logic usb_tx_valid,
  output logic [7:0] usb_tx_data,
  output logic usb_tx_last,
  output logic port_five_power_on,
  output logic port_connected,
  output logic irq
);
  localparam int PW = $clog2(FIFO_DEPTH) + 1;

  typedef struct packed {
    logic bus_ack;
    logic [31:0] rdata;
    logic [6:0] faddr;
    logic [6:0] pend_addr;
    logic pend_set;
    logic fen_flag;
    logic [3:0] irq_bits;
    logic [3:0] irq_mask;
    logic ep0_rx_en;
    logic ep0_tx_en;
    logic [63:0] setup;
    ehf_pkg::ehf_cs_t cstage;
    logic [FIFO_DEPTH-1:0][7:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [3:0] bcnt;
    logic [3:0] sent;
    logic clr;
    logic sow;
    logic stl;
    logic send_en;
    logic ep1_en;
    logic seq;
    logic st_stall;
    logic st_nack;
    logic st_err;
    logic st_ack;
    logic undr;
    logic tx_fifo_overrun_flag;
    ehf_pkg::ehf_tx_t tx;
    logic ep0_wait;
    logic rsp_v;
    ehf_pkg::ehf_rsp_t rsp;
    logic rsp_d1;
    logic txv;
    logic [7:0] txd;
    logic txl;
  } ehf_state_t;

  ehf_state_t state_ff;
  ehf_state_t nxt_state;
  logic req;
  logic done;
  logic wr;
  logic [7:0] wd;
  logic attached;
  logic hit;
  logic [PW-1:0] level;
  logic [31:0] rd;

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  function automatic logic [PW-1:0] ehf_level(input logic [PW-1:0] w,
                                               input logic [PW-1:0] r);
    ehf_level = w - r;
  endfunction

  assign req = avs_read | avs_write;
  assign done = req & state_ff.bus_ack;
  assign wr = avs_write & done & avs_byteenable[0];
  assign wd = avs_writedata[7:0];
  // the hub sees port 5 only once both ep0 directions are on
  assign attached = state_ff.ep0_rx_en & state_ff.ep0_tx_en; // see [RL3]
  assign hit = usb_tok_valid & attached
               & (usb_tok_addr == state_ff.faddr); // see [RL4]
  assign level = ehf_level(state_ff.wr_ptr, state_ff.rd_ptr);

  // ************************************************************
  // register read mux
  // ************************************************************
  always_comb begin
    rd = 32'h0;
    case (avs_address)
      `EHF_FADDR_OFS: rd = {24'h0, state_ff.fen_flag, state_ff.faddr};
      `EHF_INT_OFS: rd = {28'h0, state_ff.irq_bits};
      `EHF_MASK_OFS: rd = {28'h0, state_ff.irq_mask};
      `EHF_EP0_CTL_OFS: rd = {25'h0, state_ff.cstage, 2'h0,
                              state_ff.ep0_tx_en, state_ff.ep0_rx_en};
      `EHF_EP1_BCNT_OFS: rd = {28'h0, state_ff.bcnt};
      `EHF_EP1_CTL_OFS: rd = {24'h0, state_ff.clr, state_ff.sow, 2'h0,
                              state_ff.stl, 1'h0, state_ff.send_en,
                              state_ff.ep1_en};
      `EHF_EP1_STAT_OFS: rd = {24'h0, state_ff.seq, 3'h0, state_ff.st_stall,
                               state_ff.st_nack, state_ff.st_err,
                               state_ff.st_ack};
      `EHF_EP1_FLAG_OFS: rd = {28'h0, level == '0,
                               level == PW'(FIFO_DEPTH), state_ff.undr,
                               state_ff.tx_fifo_overrun_flag};
      `EHF_SETUP_LO_OFS: rd = state_ff.setup[31:0];
      `EHF_SETUP_HI_OFS: rd = state_ff.setup[63:32];
      default: rd = 32'h0;
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_state.rsp_v = 1'b0;
    nxt_state.txv = 1'b0;
    nxt_state.txl = 1'b0;
    // one wait cycle per access; read data captured before it is released
    nxt_state.bus_ack = req & ~state_ff.bus_ack;
    if (req & ~state_ff.bus_ack) begin
      nxt_state.rdata = rd;
    end
    nxt_state.fen_flag = usb_port_enable; // see [RL11]

    // software writes come first so that hardware sets below win
    if (wr) begin
      case (avs_address)
        `EHF_INT_OFS: begin
          nxt_state.irq_bits[`EHF_INT_EP0_RX] = state_ff.irq_bits[0] & ~wd[0];
          nxt_state.irq_bits[`EHF_INT_EP0_TX] = state_ff.irq_bits[1] & ~wd[1];
          nxt_state.irq_bits[`EHF_INT_FUNCTION_RESET_FLAG] = state_ff.irq_bits[3] & ~wd[3];
        end
        `EHF_MASK_OFS: nxt_state.irq_mask = wd[3:0];
        `EHF_EP0_CTL_OFS: begin
          nxt_state.ep0_rx_en = wd[0];
          nxt_state.ep0_tx_en = wd[1];
        end
        `EHF_EP1_DATA_OFS: begin
          if (level == PW'(FIFO_DEPTH)) begin
            nxt_state.tx_fifo_overrun_flag = 1'b1; // see [RL16]
          end else begin
            nxt_state.mem[state_ff.wr_ptr[PW-2:0]] = wd;
            nxt_state.wr_ptr = state_ff.wr_ptr + 1'b1;
          end
        end
        `EHF_EP1_BCNT_OFS: begin
          nxt_state.bcnt = wd[3:0];
          nxt_state.send_en = 1'b1; // see [RL19]
        end
        `EHF_EP1_CTL_OFS: begin
          nxt_state.clr = wd[`EHF_CTL_CLR];
          nxt_state.sow = wd[`EHF_CTL_SOW];
          nxt_state.stl = wd[`EHF_CTL_STL];
          nxt_state.send_en = wd[`EHF_CTL_FEN];
          nxt_state.ep1_en = wd[`EHF_CTL_EN];
        end
        `EHF_EP1_STAT_OFS: begin
          if (state_ff.sow) begin
            nxt_state.seq = wd[`EHF_STAT_SEQ]; // see [RL23]
          end
          nxt_state.st_ack = state_ff.st_ack & wd[0]; // see [RL21]
        end
        // overrun is only let go once the fifo clear has finished
        `EHF_EP1_FLAG_OFS: begin
          if (~state_ff.clr) begin
            nxt_state.tx_fifo_overrun_flag = state_ff.tx_fifo_overrun_flag & wd[`EHF_FLAG_TX_FIFO_OVERRUN_FLAG]; // see [RL18]
          end
        end
        default: ;
      endcase
    end

    // fifo clear takes one cycle, then the bit drops by itself
    if (state_ff.clr) begin
      nxt_state.wr_ptr = '0; // see [RL17]
      nxt_state.rd_ptr = '0;
      nxt_state.undr = 1'b0;
      nxt_state.send_en = 1'b0;
      nxt_state.clr = 1'b0;
    end

    // ep1 packet streaming, one byte per cycle straight from the fifo
    case (state_ff.tx)
      ehf_pkg::EHF_TX_SEND: begin
        nxt_state.txv = 1'b1;
        nxt_state.txd = 8'h00;
        if (4'(state_ff.sent) < 4'(level)) begin
          nxt_state.txd = state_ff.mem[PW'(state_ff.rd_ptr + PW'(state_ff.sent))
                                       & PW'(FIFO_DEPTH - 1)];
        end else begin
          nxt_state.undr = 1'b1;
        end
        nxt_state.sent = state_ff.sent + 1'b1;
        if (state_ff.sent + 1'b1 == state_ff.bcnt) begin
          nxt_state.txl = 1'b1;
          nxt_state.tx = ehf_pkg::EHF_TX_WAIT;
        end
      end
      ehf_pkg::EHF_TX_WAIT: begin
        if (usb_hs_ack) begin
          nxt_state.st_ack = 1'b1; // see [RL20]
          nxt_state.st_err = 1'b0;
          nxt_state.st_nack = 1'b0;
          nxt_state.st_stall = 1'b0;
          nxt_state.send_en = 1'b0;
          nxt_state.seq = ~state_ff.seq; // see [RL23]
          nxt_state.rd_ptr = state_ff.rd_ptr + PW'(state_ff.bcnt);
          nxt_state.tx = ehf_pkg::EHF_TX_IDLE;
        end else if (usb_hs_fail) begin
          // packet stays in the fifo for the host to retry
          nxt_state.st_err = 1'b1;
          nxt_state.tx = ehf_pkg::EHF_TX_IDLE;
        end
      end
      default: begin
        if (hit && usb_tok_ep == 4'h1 && usb_tok_pid == 2'(ehf_pkg::EHF_PID_IN)
            && state_ff.ep1_en) begin
          nxt_state.rsp_v = 1'b1;
          nxt_state.rsp_d1 = state_ff.seq;
          if (state_ff.send_en && ~state_ff.clr) begin
            nxt_state.rsp = ehf_pkg::EHF_RSP_DATA; // see [RL15]
            nxt_state.sent = 4'h0;
            nxt_state.tx = (state_ff.bcnt == 4'h0) ? ehf_pkg::EHF_TX_WAIT :
                           ehf_pkg::EHF_TX_SEND;
          end else begin
            nxt_state.rsp = state_ff.stl ? ehf_pkg::EHF_RSP_STALL :
                            ehf_pkg::EHF_RSP_NACK; // see [RL22]
            nxt_state.st_stall = state_ff.stl;
            nxt_state.st_nack = ~state_ff.stl;
            nxt_state.st_err = 1'b0;
            nxt_state.st_ack = 1'b0;
          end
        end
      end
    endcase

    // ep1 interrupt follows its sources and drops when all are cleared
    nxt_state.irq_bits[`EHF_INT_EP1_TX] = nxt_state.st_ack | nxt_state.tx_fifo_overrun_flag
                                          | nxt_state.undr; // see [RL18]

    // ************************************************************
    // ep0 control stage routing
    // ************************************************************
    if (hit && usb_tok_ep == 4'h0) begin
      nxt_state.rsp_v = 1'b1;
      nxt_state.rsp = ehf_pkg::EHF_RSP_ACK;
      case (usb_tok_pid)
        2'(ehf_pkg::EHF_PID_SETUP): begin
          if (usb_setup_data[7:0] == `EHF_RTYPE_STD_DEV &&
              usb_setup_data[15:8] == `EHF_REQ_SET_ADDR) begin
            nxt_state.pend_addr = usb_setup_data[22:16]; // see [RL12]
            nxt_state.pend_set = 1'b1;
            nxt_state.cstage = ehf_pkg::EHF_CS_STATUS_IN;
          end else begin
            nxt_state.setup = usb_setup_data;
            nxt_state.irq_bits[`EHF_INT_EP0_RX] = 1'b1;
            if (usb_setup_data[7]) begin
              nxt_state.cstage = ehf_pkg::EHF_CS_DATA_IN; // see [RL13]
            end else if (usb_setup_data[63:48] != 16'h0) begin
              nxt_state.cstage = ehf_pkg::EHF_CS_DATA_OUT;
            end else begin
              nxt_state.cstage = ehf_pkg::EHF_CS_STATUS_IN; // see [RL14]
            end
          end
        end
        2'(ehf_pkg::EHF_PID_OUT): begin
          nxt_state.irq_bits[`EHF_INT_EP0_RX] = 1'b1;
          if (state_ff.cstage == ehf_pkg::EHF_CS_DATA_IN ||
              state_ff.cstage == ehf_pkg::EHF_CS_STATUS_OUT) begin
            nxt_state.cstage = ehf_pkg::EHF_CS_IDLE; // see [RL13]
          end
        end
        default: begin
          // ep0 payload comes from the mcu side; only zero-length status here
          if (state_ff.cstage == ehf_pkg::EHF_CS_STATUS_IN ||
              state_ff.cstage == ehf_pkg::EHF_CS_DATA_OUT) begin
            nxt_state.rsp = ehf_pkg::EHF_RSP_DATA;
            nxt_state.rsp_d1 = 1'b1;
            nxt_state.ep0_wait = 1'b1;
          end else begin
            nxt_state.rsp = ehf_pkg::EHF_RSP_NACK;
          end
          if (state_ff.cstage == ehf_pkg::EHF_CS_DATA_IN) begin
            nxt_state.cstage = ehf_pkg::EHF_CS_STATUS_OUT;
          end
        end
      endcase
    end
    if (state_ff.ep0_wait && (usb_hs_ack || usb_hs_fail)) begin
      nxt_state.ep0_wait = 1'b0;
      if (usb_hs_ack) begin
        nxt_state.irq_bits[`EHF_INT_EP0_TX] = 1'b1;
        nxt_state.cstage = ehf_pkg::EHF_CS_IDLE;
        if (state_ff.pend_set) begin
          nxt_state.faddr = state_ff.pend_addr; // see [RL12]
          nxt_state.pend_set = 1'b0;
        end
      end
    end

    // host port reset wipes the function side, keeping ep0 enables and masks
    if (usb_port_reset) begin
      nxt_state = '0; // see [RL8]
      nxt_state.bus_ack = req & ~state_ff.bus_ack;
      nxt_state.rdata = (req & ~state_ff.bus_ack) ? rd : state_ff.rdata;
      nxt_state.ep0_rx_en = state_ff.ep0_rx_en;
      nxt_state.ep0_tx_en = state_ff.ep0_tx_en;
      nxt_state.irq_mask = state_ff.irq_mask;
      nxt_state.fen_flag = usb_port_enable;
      nxt_state.irq_bits[`EHF_INT_FUNCTION_RESET_FLAG] = 1'b1; // see [RL7]
    end
  end

  // all-zero is the documented reset image: address 0, detached
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_ff <= '0; // see [RL1] see [RL2]
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign avs_waitrequest = req & ~state_ff.bus_ack;
  assign avs_readdata = state_ff.rdata;
  assign usb_resp_valid = state_ff.rsp_v;
  assign usb_resp_code = state_ff.rsp;
  assign usb_resp_data1 = state_ff.rsp_d1;
  assign usb_tx_valid = state_ff.txv;
  assign usb_tx_data = state_ff.txd;
  assign usb_tx_last = state_ff.txl;
  assign port_five_power_on = usb_port_power; // see [RL10]
  assign port_connected = attached;
  assign irq = |(state_ff.irq_bits & state_ff.irq_mask); // see [RL5] see [RL24]

  // ************************************************************
  // assertions
  // ************************************************************
  sequence s_bcnt_write;
    wr && avs_address == `EHF_EP1_BCNT_OFS;
  endsequence
  sequence s_ep1_ack;
    state_ff.tx == ehf_pkg::EHF_TX_WAIT && usb_hs_ack && !usb_port_reset;
  endsequence

  a_irq_masked_or: assert property ( // see [RL5]
    s_ep1_ack |=> irq || !state_ff.irq_mask[`EHF_INT_EP1_TX])
    else $error("irq not raised for unmasked ep1 interrupt");
  a_masked_no_irq: assert property ( // see [RL6]
    usb_port_reset && !state_ff.irq_mask[`EHF_INT_FUNCTION_RESET_FLAG] |=>
    state_ff.irq_bits[`EHF_INT_FUNCTION_RESET_FLAG] && !irq)
    else $error("masked reset flag drove irq");
  a_function_reset_flag_on_reset: assert property ( // see [RL7]
    usb_port_reset |=> state_ff.irq_bits[`EHF_INT_FUNCTION_RESET_FLAG] && state_ff.faddr == 0
    && state_ff.send_en == 0)
    else $error("port reset did not set flag and clear function");
  a_fen_follows: assert property ( // see [RL11]
    usb_port_enable |=> state_ff.fen_flag)
    else $error("function enabled flag not set");
  a_bcnt_arms: assert property ( // see [RL19]
    s_bcnt_write and !usb_port_reset && !state_ff.clr |=> state_ff.send_en)
    else $error("byte count write did not arm send");
  a_ack_sets: assert property ( // see [RL20]
    s_ep1_ack |=> state_ff.st_ack && !state_ff.send_en
    && state_ff.irq_bits[`EHF_INT_EP1_TX]
    && state_ff.seq != $past(state_ff.seq))
    else $error("ep1 ack did not update status");
  a_clr_selfclr: assert property ( // see [RL17]
    state_ff.clr |=> !state_ff.clr && state_ff.wr_ptr == 0)
    else $error("fifo clear did not complete in one cycle");
  a_overrun_flag: assert property ( // see [RL16]
    wr && avs_address == `EHF_EP1_DATA_OFS && level == PW'(FIFO_DEPTH)
    && !usb_port_reset |=> state_ff.tx_fifo_overrun_flag && state_ff.irq_bits[`EHF_INT_EP1_TX])
    else $error("overrun not flagged");
  a_nack_stall: assert property ( // see [RL22]
    state_ff.rsp_v && state_ff.rsp == ehf_pkg::EHF_RSP_STALL |->
    state_ff.stl || state_ff.st_stall)
    else $error("stall without stall control");
  a_detached: assert property ( // see [RL3]
    !attached |=> !state_ff.rsp_v)
    else $error("detached function answered a token");
endmodule

`default_nettype wire

// ==== verification/ehf_host_model.sv ====
// usb host side model: sends tokens and handshakes, records the answers
`timescale 1ns/1ps
`default_nettype none

module ehf_host_model (
  input wire logic ref_clk,
  input wire logic resp_valid,
  input wire logic [1:0] resp_code,
  input wire logic resp_data1,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tok_valid,
  output logic [1:0] tok_pid,
  output logic [6:0] tok_addr,
  output logic [3:0] tok_ep,
  output logic [63:0] setup_data,
  output logic hs_ack,
  output logic hs_fail
);
  logic got;
  logic [1:0] code;
  logic data1;
  logic last;
  logic [7:0] rxq[$];

  initial begin
    tok_valid = 1'b0;
    tok_pid = 2'h0;
    tok_addr = 7'h0;
    tok_ep = 4'h0;
    setup_data = 64'h0;
    hs_ack = 1'b0;
    hs_fail = 1'b0;
  end

  // ******************************
  // one transaction, handshake only after a data answer
  // ******************************
  task automatic xfer(input logic [1:0] pid, input logic [6:0] a,
                      input logic [3:0] ep, input logic [63:0] sd,
                      input int nb, input int dly);
    int t;
    rxq.delete();
    t = 0;
    last = 1'b0;
    @(posedge ref_clk);
    tok_valid <= 1'b1;
    tok_pid <= pid;
    tok_addr <= a;
    tok_ep <= ep;
    setup_data <= sd;
    @(posedge ref_clk);
    tok_valid <= 1'b0;
    // setup bytes are valid only with the token, so scramble them after
    setup_data <= ~sd;
    @(negedge ref_clk);
    got = resp_valid;
    code = resp_code;
    data1 = resp_data1;
    if (got === 1'b1 && code === 2'h1) begin
      while (rxq.size() < nb && t < 40) begin
        @(negedge ref_clk);
        if (tx_valid === 1'b1) begin
          rxq.push_back(tx_data);
          last = tx_last;
        end
        t++;
      end
      repeat (dly) @(posedge ref_clk);
      @(posedge ref_clk);
      hs_ack <= 1'b1;
      @(posedge ref_clk);
      hs_ack <= 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// ==== verification/usb_hub_embedded_function_ctrl_bench.sv ====
// self-checking bench of the embedded function control block
`include "ehf_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module usb_hub_embedded_function_ctrl_bench;
  logic ref_clk, sys_rst, avs_read, avs_write, avs_waitrequest, irq;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic pw, pe, pr, tv, ha, hf, rv, rd1, txv, txl, p5, pc;
  logic [1:0] tp, rc;
  logic [6:0] ta;
  logic [3:0] te;
  logic [63:0] sdat;
  logic [7:0] txd;
  int bad_count = 0;
  int checked = 0;

  ehf_func_ctrl dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .usb_port_power(pw), .usb_port_enable(pe), .usb_port_reset(pr),
    .usb_tok_valid(tv), .usb_tok_pid(tp), .usb_tok_addr(ta),
    .usb_tok_ep(te), .usb_setup_data(sdat), .usb_hs_ack(ha),
    .usb_hs_fail(hf), .usb_resp_valid(rv), .usb_resp_code(rc),
    .usb_resp_data1(rd1), .usb_tx_valid(txv), .usb_tx_data(txd),
    .usb_tx_last(txl), .port_five_power_on(p5), .port_connected(pc),
    .irq(irq));
  ehf_host_model host (.ref_clk(ref_clk), .resp_valid(rv),
    .resp_code(rc), .resp_data1(rd1), .tx_valid(txv), .tx_data(txd),
    .tx_last(txl), .tok_valid(tv), .tok_pid(tp), .tok_addr(ta),
    .tok_ep(te), .setup_data(sdat), .hs_ack(ha), .hs_fail(hf));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ******************************
  // helpers
  // ******************************
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    logic wt;
    int t;
    t = 0;
    @(posedge ref_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      wt = avs_waitrequest;
      q = avs_readdata;
      t++;
    end while (wt !== 1'b0 && t < 20);
    if (t >= 20) bad_count++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    print_verdict();
  end

  // ******************************
  // main sequence
  // ******************************
  initial begin
    logic [31:0] s, q;
    logic [6:0] na;
    logic [63:0] sd;
    logic [7:0] qm[$];
    int n, tog;
    {sys_rst, avs_read, avs_write, pw, pe, pr} = 6'h20;
    {avs_address, avs_writedata, avs_byteenable} = {8'h0, 32'h0, 4'hf};
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int a = 0; a <= 44; a += 4) begin
      rdc("reset", a[7:0], (a == 32) ? 32'h8 : 32'h0);
    end
    chk("detached", pc, 1'b0);
    pw <= 1'b1;
    wr(`EHF_EP0_CTL_OFS, 32'h1);
    @(negedge ref_clk);
    chk("power", p5, 1'b1);
    chk("half enabled", pc, 1'b0);
    wr(`EHF_EP0_CTL_OFS, 32'h3);
    @(negedge ref_clk);
    chk("attached", pc, 1'b1);
    wr(`EHF_MASK_OFS, 32'h4);
    wr(`EHF_EP1_CTL_OFS, 32'h1);
    pr <= 1'b1;
    @(posedge ref_clk);
    pr <= 1'b0;
    rdc("reset flag", `EHF_INT_OFS, 32'h8);
    chk("masked irq", irq, 1'b0);
    rdc("kept enables", `EHF_EP0_CTL_OFS, 32'h3);
    rdc("kept mask", `EHF_MASK_OFS, 32'h4);
    rdc("ep1 ctl", `EHF_EP1_CTL_OFS, 32'h0);
    wr(`EHF_MASK_OFS, 32'hc);
    @(negedge ref_clk);
    chk("irq on", irq, 1'b1);
    wr(`EHF_INT_OFS, 32'h8);
    @(negedge ref_clk);
    chk("irq off", irq, 1'b0);
    pe <= 1'b1;
    rdc("enabled", `EHF_FADDR_OFS, 32'h80);
    s = lfsr(32'he935);
    na = s[6:0] | 7'h1;
    sd = {32'h0, 9'h0, na, `EHF_REQ_SET_ADDR, `EHF_RTYPE_STD_DEV};
    host.xfer(2'h0, 7'h0, 4'h0, sd, 0, 0);
    chk("setup", {host.got, host.code}, 3'h4);
    rdc("not forwarded", `EHF_SETUP_LO_OFS, 32'h0);
    rdc("stage", `EHF_EP0_CTL_OFS, 32'h33);
    host.xfer(2'h1, 7'h0, 4'h0, 64'h0, 0, 1);
    chk("status in", {host.got, host.code, host.data1}, 4'hb);
    rdc("address", `EHF_FADDR_OFS, {24'h0, 1'b1, na});
    rdc("ep0 ints", `EHF_INT_OFS, 32'h2);
    wr(`EHF_INT_OFS, 32'h3);
    sd = {16'h8, 32'h0, s[15:8], 8'h80};
    host.xfer(2'h0, na, 4'h0, sd, 0, 0);
    rdc("setup copy", `EHF_SETUP_LO_OFS, sd[31:0]);
    rdc("read stage", `EHF_EP0_CTL_OFS, 32'h13);
    host.xfer(2'h2, na, 4'h0, 64'h0, 0, 0);
    chk("out status", {host.got, host.code}, 3'h4);
    rdc("ep0 rx int", `EHF_INT_OFS, 32'h1);
    wr(`EHF_INT_OFS, 32'h1);
    wr(`EHF_EP1_CTL_OFS, 32'h1);
    host.xfer(2'h1, na, 4'h1, 64'h0, 0, 0);
    chk("nack", host.code, 2'h2);
    rdc("nack stat", `EHF_EP1_STAT_OFS, 32'h4);
    wr(`EHF_EP1_CTL_OFS, 32'h9);
    host.xfer(2'h1, na, 4'h1, 64'h0, 0, 0);
    chk("stall", host.code, 2'h3);
    rdc("stall stat", `EHF_EP1_STAT_OFS, 32'h8);
    wr(`EHF_EP1_CTL_OFS, 32'h1);
    for (int i = 0; i < 9; i++) begin
      s = lfsr(s);
      wr(`EHF_EP1_DATA_OFS, {24'h0, s[7:0]});
    end
    rdc("overrun", `EHF_EP1_FLAG_OFS, 32'h5);
    rdc("overrun int", `EHF_INT_OFS, 32'h4);
    wr(`EHF_EP1_CTL_OFS, 32'h81);
    n = 0;
    do begin
      acc(1'b0, `EHF_EP1_CTL_OFS, 32'h0, q);
      n++;
    end while (q[7] !== 1'b0 && n < 10);
    chk("clear done", q, 32'h1);
    rdc("cleared flags", `EHF_EP1_FLAG_OFS, 32'h9);
    wr(`EHF_EP1_FLAG_OFS, 32'h0);
    rdc("int dropped", `EHF_INT_OFS, 32'h0);
    tog = 0;
    for (int k = 0; k < 2; k++) begin
      s = lfsr(s);
      n = (k == 1) ? 8 : 1 + s[2:0];
      qm.delete();
      for (int i = 0; i < n; i++) begin
        s = lfsr(s);
        qm.push_back(s[7:0]);
        wr(`EHF_EP1_DATA_OFS, {24'h0, s[7:0]});
      end
      wr(`EHF_EP1_BCNT_OFS, n);
      rdc("send en", `EHF_EP1_CTL_OFS, 32'h3);
      host.xfer(2'h1, na, 4'h1, 64'h0, n, s[9:8]);
      chk("data pid", {host.code, host.data1}, {2'h1, tog[0]});
      chk("count", host.rxq.size(), n);
      chk("last", host.last, 1'b1);
      for (int i = 0; i < n; i++) begin
        chk("byte", host.rxq[i], qm[i]);
      end
      tog = 1 - tog;
      rdc("ack stat", `EHF_EP1_STAT_OFS, {24'h0, tog[0], 7'h1});
      rdc("send off", `EHF_EP1_CTL_OFS, 32'h1);
      rdc("ack int", `EHF_INT_OFS, 32'h4);
      chk("ack irq", irq, 1'b1);
      wr(`EHF_EP1_STAT_OFS, 32'h0);
      rdc("tog kept", `EHF_EP1_STAT_OFS, {24'h0, tog[0], 7'h0});
      rdc("ack int off", `EHF_INT_OFS, 32'h0);
    end
    wr(`EHF_EP1_CTL_OFS, 32'h41);
    wr(`EHF_EP1_STAT_OFS, 32'h80);
    rdc("tog written", `EHF_EP1_STAT_OFS, 32'h80);
    print_verdict();
  end
endmodule

`default_nettype wire
